// file: src/plcr_pkg.sv
package plcr_pkg;
  localparam logic [4:0] PLCR_LEDCTL_ADDR = 5'h18;
  localparam logic [4:0] PLCR_FUNCCTL_ADDR = 5'h19;
  localparam logic [4:0] PLCR_LEDMODE_ADDR = 5'h1A;
  // Direct LED control fields
  localparam int PLCR_ACTRX_BIT = 8;
  localparam int PLCR_BLINK_LO = 6;
  localparam int PLCR_SPDOVR_BIT = 5;
  localparam int PLCR_LNKOVR_BIT = 4;
  localparam int PLCR_ACTOVR_BIT = 3;
  localparam int PLCR_SPDVAL_BIT = 2;
  localparam int PLCR_LNKVAL_BIT = 1;
  localparam int PLCR_ACTVAL_BIT = 0;
  localparam logic [15:0] PLCR_LEDCTL_MASK = 16'h01FF;
  // Function control fields, then the pause and asymmetric pause bits of the advertisement words
  localparam int PLCR_XOVEN_BIT = 15;
  localparam int PLCR_FXOV_BIT = 14;
  localparam int PLCR_PRX_BIT = 13;
  localparam int PLCR_PTX_BIT = 12;
  localparam int PLCR_FERR_BIT = 11;
  localparam int PLCR_SEQ_BIT = 10;
  localparam int PLCR_PASS_BIT = 9;
  localparam int PLCR_RUN_BIT = 8;
  localparam int PLCR_BYP_BIT = 7;
  localparam int PLCR_PAUSE_BIT = 10;
  localparam int PLCR_ASYM_BIT = 11;
  // Half periods of the link LED blink at 100 MHz, in ns
  localparam longint PLCR_CLK_NS = 10;
  localparam longint PLCR_HALF_6HZ_NS = 83333333;
  localparam logic [23:0] PLCR_HALF_6HZ_CYC = 24'(PLCR_HALF_6HZ_NS / PLCR_CLK_NS);
  // Stretch of short event pulses, in ns
  localparam longint PLCR_STRETCH_NS = 50000000;
  localparam logic [23:0] PLCR_STRETCH_CYC = 24'(PLCR_STRETCH_NS / PLCR_CLK_NS);
  localparam logic [1:0] PLCR_MODE_LEVEL = 2'h0;
  localparam logic [1:0] PLCR_MODE_BLINK = 2'h1;
  // Strap is trusted once it has passed both synchroniser flops
  localparam logic [1:0] PLCR_STRAP_AGE = 2'h2;
endpackage

// file: src/plcr_stretch.sv
`timescale 1ns/10ps
// Holds a short event for a minimum visible time, or passes it when bypassed
module plcr_stretch
  import plcr_pkg::*;
#(
  parameter logic [23:0] HOLD_CYC = PLCR_STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic eventIn,
  input wire logic bypass,
  output logic eventOut
);
  typedef struct packed {
    logic [23:0] cnt;
  } plcr_str_t;
  plcr_str_t st_r;
  plcr_str_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (eventIn) begin
      st_nxt.cnt = HOLD_CYC;
    end else if (st_r.cnt != 24'h000000) begin
      st_nxt.cnt = st_r.cnt - 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign eventOut = bypass ? eventIn : (eventIn || st_r.cnt != 24'h000000);
endmodule // plcr_stretch

// file: src/plcr_regs.sv
`timescale 1ns/10ps
module plcr_regs
  import plcr_pkg::*;
#(
  parameter logic [23:0] HALF_BLINK_CYC = PLCR_HALF_6HZ_CYC,
  parameter logic [23:0] STRETCH_CYC = PLCR_STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [15:0] regRdData,
  input wire logic crossoverStrap,
  input wire logic linkUp,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic collision,
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic [15:0] localAdvertise,
  input wire logic [15:0] partnerAbility,
  input wire logic selftestError,
  output logic link_led_out,
  output logic speed_led_out,
  output logic activity_collision_led_out,
  output logic auto_crossover_en,
  output logic forced_crossover,
  output logic swapPairs,
  output logic selftest_run,
  output logic selftest_sequence_sel,
  output logic selftestInjectError
);
  typedef struct packed {
    logic [8:0] ledCtl;
    logic xovEn;
    logic fxov;
    logic ferrPulse;
    logic seqSel;
    logic passFlag;
    logic run;
    logic bypass;
    logic [1:0] ledMode;
    logic strapDone;
    logic [1:0] strapSync;
    logic [1:0] strapAge;
    logic [23:0] blinkCnt;
    logic blinkPhase;
    logic [15:0] rdData;
    logic linkLed;
    logic speedLed;
    logic forced_activity_value;
  } plcr_state_t;
  plcr_state_t st_r;
  plcr_state_t st_nxt;

  logic actSrc;
  logic actStretched;
  logic colStretched;
  logic pauseRx;
  logic pauseTx;
  logic [23:0] blinkHalf;
  logic [15:0] ledCtlView;
  logic [15:0] funcCtlView;
  logic localPause;
  logic localAsym;
  logic partPause;
  logic partAsym;

  assign actSrc = st_r.ledCtl[PLCR_ACTRX_BIT] ? rxActive : (rxActive || txActive);

  plcr_stretch #(.HOLD_CYC(STRETCH_CYC)) uActStretch (
    .clk(clk),
    .rst_n(rst_n),
    .eventIn(actSrc),
    .bypass(st_r.bypass),
    .eventOut(actStretched)
  );

  plcr_stretch #(.HOLD_CYC(STRETCH_CYC)) uColStretch (
    .clk(clk),
    .rst_n(rst_n),
    .eventIn(collision),
    .bypass(st_r.bypass),
    .eventOut(colStretched)
  );

  assign localPause = localAdvertise[PLCR_PAUSE_BIT];
  assign localAsym = localAdvertise[PLCR_ASYM_BIT];
  assign partPause = partnerAbility[PLCR_PAUSE_BIT];
  assign partAsym = partnerAbility[PLCR_ASYM_BIT];

  always_comb begin
    pauseRx = 1'b0;
    pauseTx = 1'b0;
    if (fullDuplex && linkUp) begin
      if (localPause && partPause) begin
        pauseRx = 1'b1;
        pauseTx = 1'b1;
      end else if (localPause && localAsym && !partPause && partAsym) begin
        pauseRx = 1'b1;
      end else if (!localPause && localAsym && partPause && partAsym) begin
        pauseTx = 1'b1;
      end
    end
  end

  // blink rate: each step halves the period
  assign blinkHalf = HALF_BLINK_CYC >> st_r.ledCtl[PLCR_BLINK_LO +: 2];

  assign ledCtlView = {7'h00, st_r.ledCtl};
  assign funcCtlView = {st_r.xovEn, st_r.fxov, pauseRx, pauseTx, st_r.ferrPulse, st_r.seqSel,
    st_r.passFlag, st_r.run, st_r.bypass, 7'h00};

  always_comb begin
    st_nxt = st_r;
    st_nxt.ferrPulse = 1'b0;
    st_nxt.rdData = 16'h0000;
    // strap synchronised, loaded once
    // The strap is a pin, so it crosses two flops before it is trusted
    st_nxt.strapSync = {st_r.strapSync[0], crossoverStrap};
    if (!st_r.strapDone) begin
      if (st_r.strapAge == PLCR_STRAP_AGE) begin
        st_nxt.strapDone = 1'b1;
        st_nxt.xovEn = st_r.strapSync[1];
      end else begin
        st_nxt.strapAge = st_r.strapAge + 2'h1;
      end
    end
    if (st_r.run && selftestError) begin
      st_nxt.passFlag = 1'b0;
    end
    if (regWrStb) begin
      unique case (regAddr)
        PLCR_LEDCTL_ADDR: begin
          st_nxt.ledCtl = regWrData[8:0];
        end
        PLCR_FUNCCTL_ADDR: begin
          st_nxt.xovEn = regWrData[PLCR_XOVEN_BIT];
          st_nxt.fxov = regWrData[PLCR_FXOV_BIT];
          st_nxt.ferrPulse = regWrData[PLCR_FERR_BIT] && st_r.run;
          st_nxt.seqSel = regWrData[PLCR_SEQ_BIT];
          st_nxt.bypass = regWrData[PLCR_BYP_BIT];
          st_nxt.run = regWrData[PLCR_RUN_BIT];
          // start sets pass flag, stop clears it
          if (regWrData[PLCR_RUN_BIT] && !st_r.run) begin
            st_nxt.passFlag = 1'b1;
          end else if (!regWrData[PLCR_RUN_BIT]) begin
            st_nxt.passFlag = 1'b0;
          end
        end
        PLCR_LEDMODE_ADDR: begin
          st_nxt.ledMode = regWrData[1:0];
        end
        default: begin
        end
      endcase
    end
    if (regRdStb) begin
      unique case (regAddr)
        PLCR_LEDCTL_ADDR: st_nxt.rdData = ledCtlView;
        PLCR_FUNCCTL_ADDR: st_nxt.rdData = funcCtlView;
        PLCR_LEDMODE_ADDR: st_nxt.rdData = {14'h0000, st_r.ledMode};
        default: st_nxt.rdData = 16'h0000;
      endcase
    end
    // Blink timer runs only while there is activity so the LED starts lit
    if (!actStretched) begin
      st_nxt.blinkCnt = 24'h000000;
      st_nxt.blinkPhase = 1'b0;
    end else if (st_r.blinkCnt + 24'h000001 >= blinkHalf) begin
      st_nxt.blinkCnt = 24'h000000;
      st_nxt.blinkPhase = !st_r.blinkPhase;
    end else begin
      st_nxt.blinkCnt = st_r.blinkCnt + 24'h000001;
    end
    if (st_r.ledMode == PLCR_MODE_BLINK) begin
      st_nxt.linkLed = linkUp && !(actStretched && st_r.blinkPhase);
      st_nxt.forced_activity_value = colStretched;
    end else begin
      st_nxt.linkLed = linkUp;
      st_nxt.forced_activity_value = actStretched;
    end
    st_nxt.speedLed = speed100;
    if (st_r.ledCtl[PLCR_LNKOVR_BIT]) begin
      st_nxt.linkLed = st_r.ledCtl[PLCR_LNKVAL_BIT];
    end
    if (st_r.ledCtl[PLCR_SPDOVR_BIT]) begin
      st_nxt.speedLed = st_r.ledCtl[PLCR_SPDVAL_BIT];
    end
    if (st_r.ledCtl[PLCR_ACTOVR_BIT]) begin
      st_nxt.forced_activity_value = st_r.ledCtl[PLCR_ACTVAL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign link_led_out = st_r.linkLed;
  assign speed_led_out = st_r.speedLed;
  assign activity_collision_led_out = st_r.forced_activity_value;
  assign auto_crossover_en = st_r.xovEn;
  assign forced_crossover = st_r.fxov;
  assign swapPairs = st_r.fxov;
  assign selftest_run = st_r.run;
  assign selftest_sequence_sel = st_r.seqSel;
  assign selftestInjectError = st_r.ferrPulse;

  // Assertions
  // reserved read
  led_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(regRdStb) && $past(regAddr) == PLCR_LEDCTL_ADDR |-> regRdData[15:9] == 7'h00)
    else $error("reserved LED bits not zero");

  led_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    regWrStb && regAddr == PLCR_LEDCTL_ADDR |=> st_r.ledCtl == $past(regWrData[8:0]))
    else $error("LED control write not stored");

  rd_idle_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(regRdStb) |-> regRdData == 16'h0000)
    else $error("read data outside its cycle");

  speed_override_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.ledCtl[PLCR_SPDOVR_BIT] |=> speed_led_out == $past(st_r.ledCtl[PLCR_SPDVAL_BIT]))
    else $error("speed LED not forced");

  link_override_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.ledCtl[PLCR_LNKOVR_BIT] |=> link_led_out == $past(st_r.ledCtl[PLCR_LNKVAL_BIT]))
    else $error("link LED not forced");

  act_override_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.ledCtl[PLCR_ACTOVR_BIT]
    |=> activity_collision_led_out == $past(st_r.ledCtl[PLCR_ACTVAL_BIT]))
    else $error("activity LED not forced");

  stretch_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.bypass && st_r.ledMode == PLCR_MODE_LEVEL && !st_r.ledCtl[PLCR_ACTOVR_BIT]
    |=> activity_collision_led_out == $past(actSrc))
    else $error("bypassed activity LED not following source");

  link_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.ledMode == PLCR_MODE_LEVEL && !st_r.ledCtl[PLCR_LNKOVR_BIT]
    |=> link_led_out == $past(linkUp))
    else $error("link LED not following link");

  link_blink_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.ledMode == PLCR_MODE_BLINK && !st_r.ledCtl[PLCR_LNKOVR_BIT] && !linkUp
    |=> !link_led_out)
    else $error("link LED lit without link");

  sequence ferrWrite_s;
    regWrStb && regAddr == PLCR_FUNCCTL_ADDR && regWrData[PLCR_FERR_BIT] && selftest_run;
  endsequence
  sequence ferrPulse_s;
    selftestInjectError ##1 (!selftestInjectError || $past(regWrStb));
  endsequence
  ferr_single_a: assert property (@(posedge clk) disable iff (!rst_n)
    ferrWrite_s |=> ferrPulse_s)
    else $error("error injection not one cycle");

  ferr_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !selftest_run |=> !selftestInjectError)
    else $error("error injected while self test stopped");

  pass_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    !st_r.passFlag && st_r.run && !(regWrStb && regAddr == PLCR_FUNCCTL_ADDR)
    |=> !st_r.passFlag)
    else $error("pass flag recovered while running");

  pause_duplex_a: assert property (@(posedge clk) disable iff (!rst_n)
    !fullDuplex |-> !pauseRx && !pauseTx)
    else $error("pause resolved without full duplex");

  pause_both_a: assert property (@(posedge clk) disable iff (!rst_n)
    fullDuplex && linkUp && localPause && partPause |-> pauseRx && pauseTx)
    else $error("symmetric pause not resolved");

  swap_forced_a: assert property (@(posedge clk) disable iff (!rst_n)
    regWrStb && regAddr == PLCR_FUNCCTL_ADDR |=> swapPairs == $past(regWrData[PLCR_FXOV_BIT]))
    else $error("pair swap not following write");

  strap_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    !st_r.strapDone && st_r.strapAge == PLCR_STRAP_AGE
    && !(regWrStb && regAddr == PLCR_FUNCCTL_ADDR)
    |=> auto_crossover_en == $past(st_r.strapSync[1]))
    else $error("strap default not loaded");

  xov_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    regWrStb && regAddr == PLCR_FUNCCTL_ADDR
    |=> auto_crossover_en == $past(regWrData[PLCR_XOVEN_BIT]))
    else $error("auto crossover not following write");
endmodule // plcr_regs

// file: verif/plcr_testbench.sv
`timescale 1ns/10ps
module testbench
  import plcr_pkg::*;
  ;
  // Short blink half period so all four rates fit in a brief run
  localparam logic [23:0] HALF = 24'h000020;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [15:0] regRdData;
  logic strap = 1'b1;
  logic linkUp = 1'b0;
  logic spd = 1'b0;
  logic fdx = 1'b0;
  logic col = 1'b0;
  logic txAct = 1'b0;
  logic rxAct = 1'b0;
  logic [15:0] locAdv = 16'h0000;
  logic [15:0] parAdv = 16'h0000;
  logic stErr = 1'b0;
  logic linkLed, forced_speed_value, forced_activity_value, xovEn, fxov, swp, run, seq, inj;
  int error_cnt = 0;
  int samples_checked = 0;
  int injCnt = 0;
  int n;
  logic [15:0] d;
  logic [15:0] v;

  always #5 clk = ~clk;
  always @(posedge clk) if (inj === 1'b1) injCnt++;

  plcr_regs #(.HALF_BLINK_CYC(HALF), .STRETCH_CYC(24'h000008)) dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .crossoverStrap(strap), .linkUp(linkUp), .speed100(spd), .fullDuplex(fdx),
    .collision(col), .txActive(txAct), .rxActive(rxAct), .localAdvertise(locAdv),
    .partnerAbility(parAdv), .selftestError(stErr), .link_led_out(linkLed),
    .speed_led_out(forced_speed_value), .activity_collision_led_out(forced_activity_value),
    .auto_crossover_en(xovEn), .forced_crossover(fxov), .swapPairs(swp),
    .selftest_run(run), .selftest_sequence_sel(seq), .selftestInjectError(inj));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] val);
    @(posedge clk);
    regAddr <= a;
    regWrData <= val;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] val);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1;
    val = regRdData;
  endtask

  task automatic waitLed(input logic lv, inout int c);
    while (linkLed !== lv && c < 300) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // Cycles from one rising edge of the link LED to the next
  task automatic period(output int p);
    int t;
    t = 0;
    p = 0;
    waitLed(1'b0, t);
    waitLed(1'b1, t);
    waitLed(1'b0, p);
    waitLed(1'b1, p);
    if (t >= 300 || p >= 300) begin
      error_cnt++;
      conclude();
    end
  endtask

  // Returns {receive, transmit}; index is {localAsym, localPause, partnerAsym, partnerPause}
  function automatic logic [1:0] pauseExp(input logic [3:0] c);
    if (c[2] && c[0]) return 2'h3;
    if (c == 4'hB) return 2'h1;
    if (c == 4'hE) return 2'h2;
    return 2'h0;
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    d = $urandom(32'h7B0FDA28);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(PLCR_LEDCTL_ADDR, d);
    chk("ledctl reset", d, 16'h0000);
    rd(PLCR_FUNCCTL_ADDR, d);
    chk("phyctl reset", d, 16'h8000);
    $display("test reset done");
    repeat (8) begin
      v = $urandom;
      wr(PLCR_LEDCTL_ADDR, v);
      wr(5'h03, ~v);
      rd(PLCR_LEDCTL_ADDR, d);
      chk("ledctl", d, v & 16'h01FF);
      rd(5'h03, d);
      chk("unmapped", d, 16'h0000);
    end
    $display("test readback done");
    wr(PLCR_FUNCCTL_ADDR, 16'h0080);
    repeat (24) begin
      v = $urandom & 16'h013F;
      wr(PLCR_LEDCTL_ADDR, v);
      {linkUp, spd, txAct, rxAct} <= 4'($urandom);
      repeat (3) @(posedge clk);
      #1;
      chk("leds", {13'h0, linkLed, forced_speed_value, forced_activity_value}, {13'h0, v[4] ? v[1] : linkUp,
          v[5] ? v[2] : spd, v[3] ? v[0] : (rxAct | (txAct & ~v[8]))});
    end
    $display("test override done");
    wr(PLCR_LEDCTL_ADDR, 16'h0000);
    for (int b = 1; b >= 0; b--) begin
      wr(PLCR_FUNCCTL_ADDR, b ? 16'h0080 : 16'h0000);
      {txAct, rxAct} <= 2'h0;
      repeat (12) @(posedge clk);
      rxAct <= 1'b1;
      @(posedge clk);
      rxAct <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("stretch", {15'h0, forced_activity_value}, b ? 16'h0000 : 16'h0001);
    end
    $display("test stretch done");
    wr(PLCR_FUNCCTL_ADDR, 16'h4000);
    repeat (2) @(posedge clk);
    #1;
    chk("xover on", {13'h0, xovEn, fxov, swp}, 16'h0003);
    wr(PLCR_FUNCCTL_ADDR, 16'h8000);
    repeat (2) @(posedge clk);
    #1;
    chk("xover off", {13'h0, xovEn, fxov, swp}, 16'h0004);
    $display("test crossover done");
    linkUp <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      fdx <= ~i[4];
      locAdv <= {4'h0, i[3:2], 10'h000};
      parAdv <= {4'h0, i[1:0], 10'h000};
      repeat (3) @(posedge clk);
      rd(PLCR_FUNCCTL_ADDR, d);
      chk("pause", {14'h0, d[13:12]}, {14'h0, i[4] ? 2'h0 : pauseExp(i[3:0])});
    end
    $display("test pause done");
    wr(PLCR_FUNCCTL_ADDR, 16'h0500);
    rd(PLCR_FUNCCTL_ADDR, d);
    chk("bist on", {d[10:8], 11'h0, run, seq}, 16'hE003);
    injCnt = 0;
    wr(PLCR_FUNCCTL_ADDR, 16'h0D00);
    repeat (6) @(posedge clk);
    rd(PLCR_FUNCCTL_ADDR, d);
    chk("inject", {d[11:9], 13'(injCnt)}, 16'h6001);
    @(posedge clk);
    stErr <= 1'b1;
    @(posedge clk);
    stErr <= 1'b0;
    wr(PLCR_FUNCCTL_ADDR, 16'h0500);
    rd(PLCR_FUNCCTL_ADDR, d);
    chk("fail latch", {15'h0, d[9]}, 16'h0000);
    wr(PLCR_FUNCCTL_ADDR, 16'h0000);
    rd(PLCR_FUNCCTL_ADDR, d);
    chk("bist stop", {13'h0, d[9:8], run}, 16'h0000);
    wr(PLCR_FUNCCTL_ADDR, 16'h0100);
    rd(PLCR_FUNCCTL_ADDR, d);
    chk("bist restart", {13'h0, d[9:8], seq}, 16'h0006);
    $display("test selftest done");
    wr(PLCR_LEDMODE_ADDR, 16'h0001);
    wr(PLCR_FUNCCTL_ADDR, 16'h0080);
    {linkUp, txAct, rxAct} <= 3'h6;
    for (int k = 0; k < 4; k++) begin
      wr(PLCR_LEDCTL_ADDR, 16'(k) << 6);
      // First period may straddle the rate change
      period(n);
      period(n);
      chk("blink period", 16'(n), 16'(2 * (HALF >> k)));
    end
    txAct <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("link steady", {15'h0, linkLed}, 16'h0001);
    $display("test blink done");
    conclude();
  end
endmodule // testbench
